// File: shared/bcc_pkg.sv
// Constants, register map and carrier types for the BCD time and calendar counter.
// Assumes a single 20 MHz system clock; every other rate is derived from it.
`default_nettype none

package bcc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 20_000_000; // System clock rate in Hz
	localparam int STEP_MS = 10; // Period of one hundredth step in ms
	localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS; // Cycles per hundredth

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_SEC = 8'h00;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_HOUR = 8'h02;
	localparam logic [7:0] ADDR_WDAY = 8'h03;
	localparam logic [7:0] ADDR_DATE = 8'h04;
	localparam logic [7:0] ADDR_MONTH = 8'h05;
	localparam logic [7:0] ADDR_YEAR = 8'h06;
	localparam logic [7:0] ADDR_CTRL = 8'h0F;
	localparam logic [7:0] ADDR_HUND = 8'h10;
	localparam logic [7:0] ADDR_EXT_SEC = 8'h11;
	localparam logic [7:0] ADDR_EXT_MIN = 8'h12;
	localparam logic [7:0] ADDR_EXT_HOUR = 8'h13;
	localparam logic [7:0] ADDR_EXT_WDAY = 8'h14;
	localparam logic [7:0] ADDR_EXT_DATE = 8'h15;
	localparam logic [7:0] ADDR_EXT_MONTH = 8'h16;
	localparam logic [7:0] ADDR_EXT_YEAR = 8'h17;
	localparam logic [7:0] ADDR_HUND_SNAP = 8'h20;
	localparam logic [7:0] ADDR_SEC_SNAP = 8'h21;
	localparam logic [7:0] ADDR_TRIM = 8'h2C;
	localparam logic [7:0] ADDR_EVT = 8'h2F;

	////////////////////////////////////////////////////////////////////////////
	// Writable bit masks; cleared bits read as zero
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_WDAY = 8'h7F;
	localparam logic [7:0] MASK_DATE = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;
	localparam logic [7:0] MASK_TRIM = 8'h0F;
	localparam logic [7:0] MASK_EVT = 8'hF1;

	////////////////////////////////////////////////////////////////////////////
	// Bit positions
	localparam int GEN_RESET_BIT = 0; // General reset bit in control register
	localparam int EVENT_CLEAR_BIT_BIT = 0; // Event reset bit
	localparam int ECP_BIT = 7; // Capture enable bit
	localparam int EHL_BIT = 6; // Event level select bit

	////////////////////////////////////////////////////////////////////////////
	// BCD limits
	localparam logic [7:0] BCD_00 = 8'h00;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_31 = 8'h31;
	localparam logic [7:0] BCD_30 = 8'h30;
	localparam logic [7:0] BCD_29 = 8'h29;
	localparam logic [7:0] BCD_28 = 8'h28;
	localparam logic [7:0] BCD_FEB = 8'h02;
	localparam logic [7:0] BCD_APR = 8'h04;
	localparam logic [7:0] BCD_JUN = 8'h06;
	localparam logic [7:0] BCD_SEP = 8'h09;
	localparam logic [7:0] BCD_NOV = 8'h11;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] WDAY_FIRST = 8'h01; // Sunday
	localparam logic [7:0] WDAY_LAST = 8'h40; // Saturday

	////////////////////////////////////////////////////////////////////////////
	// Serial byte roles
	localparam logic [1:0] K_ADDR = 2'h0;
	localparam logic [1:0] K_PTR = 2'h1;
	localparam logic [1:0] K_DATA = 2'h2;
	localparam logic [2:0] LAST_BIT = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic [7:0] hund;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} bcc_time_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} bcc_wr_t;

	// Reset time: 00:00:00.00, Sunday, 01-01-01
	localparam bcc_time_t TIME_RESET = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
	localparam logic [7:0] TRIM_RESET = 8'h00;

endpackage : bcc_pkg

`default_nettype wire

// File: src/bcc_counter.sv
// BCD time and calendar counter with a serial two-wire register port.
// Assumes SCL and SDA arrive as raw pin levels; SDA is open drain, resolved outside.
`default_nettype none

// How it works
// - Hundredths count BCD 00-99, carry on wrap
// - Seconds count BCD 00-59, carry on wrap
// - Minutes count BCD 00-59, carry on wrap
// - Hours 00-23, wrap advances weekday and date
// - All fields but weekday packed BCD, tens upper nibble
// - Unused upper bits ignore writes, read zero
// - Weekday one-hot bit rotates left, 6 wraps
// - Sunday bit 0 to Saturday bit 6
// - Calendar correct from 2001 through 2099
// - Year divisible by four: February has 29
// - Month lengths 31, 30, or 28
// - Date, month, year BCD in 6,5,8 bits
// - Hundredths and seconds capture registers readable
// - Four-bit trim, upper zero, resets to zero
// - Event control: enable, level, reset
// - Basic and extension addresses share counters
// - Seconds write or resets clear hundredths
// - Month counts 01-12, wrap advances year
// - Year counts BCD 00-99 then wraps
module bcc_counter #(
	parameter int STEP_CYCLES = bcc_pkg::STEP_CYCLES, // Cycles per hundredth step
	parameter logic [6:0] DEV_ADDR = 7'h2A // Serial slave address, value arbitrary
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_event
);
	import bcc_pkg::*;

	localparam int DIV_W = $clog2(STEP_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

	typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} bcc_state_t;

	bcc_time_t t; // Live counters
	bcc_time_t next_t; // Counters after one step
	logic [7:0] trim; // Oscillator offset trim
	logic [7:0] evt; // Event control
	logic [7:0] hund_snap; // Captured hundredths
	logic [7:0] sec_snap; // Captured seconds
	logic [DIV_W-1:0] div; // Step divider
	logic step_pend; // Step waiting for a write-free cycle
	logic advance; // Step applied this cycle
	logic c_sec, c_min, c_hour, c_day, c_month, c_year; // Carries
	bcc_wr_t wr; // Host write strobe
	logic [2:0] scl_sync, sda_sync, evt_sync; // Pin synchronisers plus one delay stage
	logic scl_rise, scl_fall, start_cond, stop_cond, evt_edge;
	bcc_state_t st; // Serial engine state
	logic [1:0] kind; // Role of byte being received
	logic [2:0] cnt; // Bit counter
	logic [7:0] sh; // Receive shift register
	logic [7:0] txsh; // Transmit shift register
	logic [7:0] ptr; // Register pointer
	logic rw; // Read transfer
	logic byte_done; // Eight bits received
	logic [7:0] rd_byte; // Register byte at the pointer

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	// BCD increment of a two-digit byte
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == BCD_NINE)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Last date of month; year multiple of four is leap, valid 2001..2099
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = (y[1:0] == {y[4], 1'b0});
		case (m)
			BCD_FEB: return leap ? BCD_29 : BCD_28;
			BCD_APR, BCD_JUN, BCD_SEP, BCD_NOV: return BCD_30;
			default: return BCD_31;
		endcase
	endfunction

	// Register read map
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			ADDR_SEC, ADDR_EXT_SEC: return t.sec;
			ADDR_MIN, ADDR_EXT_MIN: return t.min;
			ADDR_HOUR, ADDR_EXT_HOUR: return t.hour;
			ADDR_WDAY, ADDR_EXT_WDAY: return t.wday;
			ADDR_DATE, ADDR_EXT_DATE: return t.date;
			ADDR_MONTH, ADDR_EXT_MONTH: return t.month;
			ADDR_YEAR, ADDR_EXT_YEAR: return t.year;
			ADDR_HUND: return t.hund;
			ADDR_HUND_SNAP: return hund_snap;
			ADDR_SEC_SNAP: return sec_snap;
			ADDR_TRIM: return trim;
			ADDR_EVT: return evt;
			default: return BCD_00; // Unmapped reads zero
		endcase
	endfunction
	always_comb rd_byte = reg_read(ptr); // Process, not assign, so counter changes are seen

	////////////////////////////////////////////////////////////////////////////
	// Time base

	// Divider making the 100 Hz step
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div <= '0;
		end else if (div == DIV_LAST) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// Step held off during a host write so the written field is not torn
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			step_pend <= 1'b0;
		end else if (div == DIV_LAST) begin
			step_pend <= 1'b1;
		end else if (advance) begin
			step_pend <= 1'b0;
		end
	end

	assign advance = step_pend && !wr.en;

	////////////////////////////////////////////////////////////////////////////
	// Ripple of carries within one step
	always_comb begin
		next_t = t;
		c_sec = 1'b0;
		c_min = 1'b0;
		c_hour = 1'b0;
		c_day = 1'b0;
		c_month = 1'b0;
		c_year = 1'b0;
		if (advance) begin
			c_sec = (t.hund == BCD_99);
			next_t.hund = c_sec ? BCD_00 : bcd_inc(t.hund);
		end
		if (c_sec) begin
			c_min = (t.sec == BCD_59);
			next_t.sec = c_min ? BCD_00 : bcd_inc(t.sec);
		end
		if (c_min) begin
			c_hour = (t.min == BCD_59);
			next_t.min = c_hour ? BCD_00 : bcd_inc(t.min);
		end
		if (c_hour) begin
			c_day = (t.hour == BCD_23);
			next_t.hour = c_day ? BCD_00 : bcd_inc(t.hour);
		end
		if (c_day) begin
			// Rotate weekday; Saturday wraps to Sunday
			next_t.wday = {1'b0, t.wday[5:0], t.wday[6]};
			c_month = (t.date == month_last(t.month, t.year));
			next_t.date = c_month ? BCD_01 : bcd_inc(t.date);
		end
		if (c_month) begin
			c_year = (t.month == BCD_12);
			next_t.month = c_year ? BCD_01 : bcd_inc(t.month);
		end
		if (c_year) begin
			next_t.year = (t.year == BCD_99) ? BCD_00 : bcd_inc(t.year);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counters and their host writes; masks keep unused bits at zero
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			t <= TIME_RESET;
		end else if (wr.en) begin
			case (wr.addr)
				ADDR_SEC, ADDR_EXT_SEC: begin
					t.sec <= wr.data & MASK_SEC;
					t.hund <= BCD_00;
				end
				ADDR_MIN, ADDR_EXT_MIN: t.min <= wr.data & MASK_MIN;
				ADDR_HOUR, ADDR_EXT_HOUR: t.hour <= wr.data & MASK_HOUR;
				ADDR_WDAY, ADDR_EXT_WDAY: t.wday <= wr.data & MASK_WDAY;
				ADDR_DATE, ADDR_EXT_DATE: t.date <= wr.data & MASK_DATE;
				ADDR_MONTH, ADDR_EXT_MONTH: t.month <= wr.data & MASK_MONTH;
				ADDR_YEAR, ADDR_EXT_YEAR: t.year <= wr.data & MASK_YEAR;
				ADDR_CTRL: begin
					// Only the general reset bit acts here
					if (wr.data[GEN_RESET_BIT])
						t.hund <= BCD_00;
				end
				ADDR_EVT: begin
					if (wr.data[EVENT_CLEAR_BIT_BIT])
						t.hund <= BCD_00;
				end
				default: ; // Hundredths and snapshots are read only
			endcase
		end else begin
			t <= next_t;
		end
	end

	// Trim register, cleared only by power-on reset
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			trim <= TRIM_RESET;
		end else if (wr.en && wr.addr == ADDR_TRIM) begin
			trim <= wr.data & MASK_TRIM;
		end
	end

	// Event control register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			evt <= BCD_00;
		end else if (wr.en && wr.addr == ADDR_EVT) begin
			evt <= wr.data & MASK_EVT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			evt_sync <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[1:0], i_scl};
			sda_sync <= {sda_sync[1:0], i_sda};
			evt_sync <= {evt_sync[1:0], i_event};
		end
	end

	assign scl_rise = scl_sync[1] && !scl_sync[2];
	assign scl_fall = !scl_sync[1] && scl_sync[2];
	assign start_cond = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
	assign stop_cond = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
	// Level select high picks the rising edge, low the falling edge
	assign evt_edge = (evt_sync[1] != evt_sync[2]) && (evt_sync[1] == evt[EHL_BIT]);

	////////////////////////////////////////////////////////////////////////////
	// Capture of hundredths and seconds on an enabled event edge
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hund_snap <= BCD_00;
			sec_snap <= BCD_00;
		end else if (evt_edge && evt[ECP_BIT]) begin
			hund_snap <= t.hund;
			sec_snap <= t.sec;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial slave: address, pointer, then data bytes with auto increment.
	// SDA changes only after SCL falls, so it is stable while SCL is high.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= ST_IDLE;
			kind <= K_ADDR;
			cnt <= '0;
			sh <= '0;
			txsh <= '0;
			ptr <= '0;
			rw <= 1'b0;
			byte_done <= 1'b0;
			o_sda_oe <= 1'b0;
			wr <= '0;
		end else begin
			wr.en <= 1'b0;
			if (start_cond) begin
				st <= ST_RX;
				kind <= K_ADDR;
				cnt <= '0;
				byte_done <= 1'b0;
				o_sda_oe <= 1'b0;
			end else if (stop_cond) begin
				st <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (st == ST_RX) begin
					sh <= {sh[6:0], sda_sync[1]};
					cnt <= cnt + 1'b1;
					byte_done <= (cnt == LAST_BIT);
				end else if (st == ST_TXACK && sda_sync[1]) begin
					st <= ST_IDLE; // Master refused more data
				end
			end else if (scl_fall) begin
				case (st)
					ST_RX: begin
						if (byte_done) begin
							byte_done <= 1'b0;
							st <= ST_ACK;
							o_sda_oe <= 1'b1; // Acknowledge by pulling low
							if (kind == K_ADDR) begin
								rw <= sh[0];
								if (sh[7:1] != DEV_ADDR) begin
									st <= ST_IDLE;
									o_sda_oe <= 1'b0;
								end
							end else if (kind == K_PTR) begin
								ptr <= sh;
							end else begin
								wr <= '{1'b1, ptr, sh};
								ptr <= ptr + 1'b1;
							end
						end
					end
					ST_ACK: begin
						if (kind == K_ADDR && rw) begin
							txsh <= {rd_byte[6:0], 1'b0};
							o_sda_oe <= !rd_byte[7];
							ptr <= ptr + 1'b1;
							cnt <= '0;
							st <= ST_TX;
						end else begin
							o_sda_oe <= 1'b0;
							kind <= (kind == K_ADDR) ? K_PTR : K_DATA;
							cnt <= '0;
							st <= ST_RX;
						end
					end
					ST_TX: begin
						if (cnt == LAST_BIT) begin
							o_sda_oe <= 1'b0; // Release for master acknowledge
							st <= ST_TXACK;
						end else begin
							o_sda_oe <= !txsh[7];
							txsh <= {txsh[6:0], 1'b0};
							cnt <= cnt + 1'b1;
						end
					end
					ST_TXACK: begin
						txsh <= {rd_byte[6:0], 1'b0};
						o_sda_oe <= !rd_byte[7];
						ptr <= ptr + 1'b1;
						cnt <= '0;
						st <= ST_TX;
					end
					default: st <= ST_IDLE;
				endcase
			end
		end
	end

	assign o_sda = 1'b0; // Open drain: only ever pulls low

	////////////////////////////////////////////////////////////////////////////
	// Checks
	hund_wrap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(advance && t.hund == BCD_99) |=> (t.hund == BCD_00 && t.sec != $past(t.sec)))
		else $error("hundredths did not wrap with carry");
	sec_wrap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(advance && t.hund == BCD_99 && t.sec == BCD_59) |=> (t.sec == BCD_00))
		else $error("seconds did not wrap at 59");
	min_wrap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_min && t.min == BCD_59) |=> (t.min == BCD_00 && t.hour != $past(t.hour)))
		else $error("minutes did not wrap at 59");
	hour_wrap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_hour && t.hour == BCD_23) |=> (t.hour == BCD_00 && t.wday != $past(t.wday)))
		else $error("hour wrap missed weekday step");
	unused_bits_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(t.sec[7] == 1'b0 && t.hour[7:6] == 2'h0 && t.date[7:6] == 2'h0 && t.month[7:5] == 3'h0))
		else $error("unused field bit set");
	wday_rotate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_day && t.wday == WDAY_LAST) |=> (t.wday == WDAY_FIRST))
		else $error("weekday did not wrap to Sunday");
	leap_feb_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_day && t.month == BCD_FEB && t.date == BCD_28 && t.year[1:0] == {t.year[4], 1'b0})
		|=> (t.date == BCD_29))
		else $error("leap February skipped the 29th");
	short_month_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_day && t.month == BCD_APR && t.date == BCD_30) |=> (t.date == BCD_01 && t.month == BCD_APR + 8'h01))
		else $error("thirty-day month overran");
	month_wrap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(c_month && t.month == BCD_12) |=> (t.month == BCD_01 && t.year != $past(t.year)))
		else $error("December did not roll the year");
	hund_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(wr.en && (wr.addr == ADDR_SEC || wr.addr == ADDR_EXT_SEC)) |=> (t.hund == BCD_00))
		else $error("seconds write left hundredths set");
	mirror_map_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(wr.en && wr.addr == ADDR_EXT_MIN) |=> (t.min == ($past(wr.data) & MASK_MIN)))
		else $error("mirror write missed the counter");
	trim_upper_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(trim[7:4] == 4'h0 && evt[3:1] == 3'h0))
		else $error("trim or event reserved bit set");

endmodule // bcc_counter

`default_nettype wire

// File: bench/bcc_host.sv
// Two-wire bus host model that sets and reads the counter's registers.
// Assumes the bench resolves the data wire with a pull-up against all pull-downs.
`default_nettype none
module bcc_host (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_pull
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bus idles released, clock high
	initial begin
		o_scl = 1'b1;
		o_pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// Phases of five clocks so the device synchroniser always sees them
	task automatic hcyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Data changes one clock after the clock falls, giving hold margin
	task automatic bit_out(input logic b);
		o_pull <= !b;
		hcyc(4);
		o_scl <= 1'b1;
		hcyc(5);
		o_scl <= 1'b0;
		hcyc(1);
	endtask
	// Sampled mid high phase, long after the device has settled
	task automatic bit_in(output logic b);
		o_pull <= 1'b0;
		hcyc(4);
		o_scl <= 1'b1;
		hcyc(3);
		b = i_sda;
		hcyc(2);
		o_scl <= 1'b0;
		hcyc(1);
	endtask
	// Data falls while clock high
	task automatic start();
		o_pull <= 1'b1;
		hcyc(5);
		o_scl <= 1'b0;
		hcyc(1);
	endtask
	// Release data, raise clock, then start again
	task automatic restart();
		o_pull <= 1'b0;
		hcyc(4);
		o_scl <= 1'b1;
		hcyc(5);
		start();
	endtask
	// Data rises while clock high, then bus idle
	task automatic stop();
		o_pull <= 1'b1;
		hcyc(4);
		o_scl <= 1'b1;
		hcyc(5);
		o_pull <= 1'b0;
		hcyc(10);
	endtask
	// Byte out MSB first; ack high when the device pulled low
	task automatic put(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(b);
		ack = !b;
	endtask
	// Byte in MSB first, then ack, or no-ack on the last byte
	task automatic take(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(last);
	endtask
endmodule // bcc_host
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench: sets time and date over the two-wire port, checks rollovers,
// capture, trim and clears. Assumes the host model and an open-drain wire with pull-up.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bcc_pkg::*;
	localparam int STEP = 32; // Short step keeps one second at 3200 clocks
	localparam logic [6:0] DEVA = 7'h2A; // Device address, value arbitrary
	logic clk, nrst, scl, pull, ev, sda_oe, sda_o;
	// Pull-up unless a party pulls low; the device's drive value counts, so a stuck high shows
	wire logic sda = (sda_oe ? sda_o : 1'b1) && !pull;
	int num_errors = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h7418;
	logic [7:0] wq[$], rq[$], eq[$];
	longint tw, tr, te;
	// Hour, date, month, year at 59:59, one second before each rollover
	logic [31:0] cases [8] = '{32'h23310121, 32'h23300433, 32'h23280205, 32'h23280204,
		32'h23290208, 32'h23311299, 32'h09150750, 32'h19300960};
	bcc_counter #(.STEP_CYCLES(STEP), .DEV_ADDR(DEVA)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_scl(scl),
		.i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_event(ev));
	bcc_host host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
	////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////////
	// Model helpers: random source, BCD to and from integers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int un(input logic [7:0] b);
		return b[7:4] * 10 + b[3:0];
	endfunction
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	function automatic int mdays(input int m, input int y);
		if (m == 2) return (y % 4 == 0) ? 29 : 28;
		if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
		return 31;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Comparisons; the hundredths one allows two steps of divider phase
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_h(input logic [7:0] got, input int e);
		tests_run++;
		if ((got[3:0] <= 4'h9 && un(got) <= e + 2 && un(got) + 2 >= e) !== 1'b1) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, bcd(e));
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Register access over the host model
	task automatic send(input logic [7:0] b);
		logic a;
		host_u.put(b, a);
		chk({7'h00, a}, 8'h01);
	endtask
	// Burst write of wq from ptr
	task automatic wr(input logic [7:0] ptr);
		host_u.start();
		send({DEVA, 1'b0});
		send(ptr);
		foreach (wq[i]) send(wq[i]);
		host_u.stop();
	endtask
	// Burst read of n bytes from ptr into rq
	task automatic rd(input logic [7:0] ptr, input int n);
		logic [7:0] b;
		rq = {};
		host_u.start();
		send({DEVA, 1'b0});
		send(ptr);
		host_u.restart();
		send({DEVA, 1'b1});
		for (int i = 0; i < n; i++) begin
			host_u.take(i == n - 1, b);
			rq.push_back(b);
		end
		host_u.stop();
	endtask
	task automatic finish_test();
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] c, r;
		logic [7:0] j;
		int h, d, m, y, wd, e;
		logic a;
		nrst = 1'b0;
		ev = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		// Trim after reset, unmapped neighbour, then a random trim value
		rd(ADDR_TRIM, 2);
		chk(rq[0], 8'h00);
		chk(rq[1], 8'h00);
		r = rnd();
		wq = {r[7:0]};
		wr(ADDR_TRIM);
		rd(ADDR_TRIM, 1);
		chk(rq[0], r[7:0] & 8'h0F);
		// Foreign address gets no ack
		host_u.start();
		host_u.put({DEVA ^ 7'h01, 1'b0}, a);
		chk({7'h00, a}, 8'h00);
		host_u.stop();
		// Rollovers; junk lands only in write-protected bits
		for (int i = 0; i < 8; i++) begin
			c = cases[i];
			r = rnd();
			j = r[15:8];
			wd = (i == 0) ? 6 : int'(r[7:0]) % 7;
			wq = {8'h59 | (j & 8'h80), 8'h59 | (j & 8'h80), c[31:24] | (j & 8'hC0), (8'h01 << wd) | (j & 8'h80),
				c[23:16] | (j & 8'hC0), c[15:8] | (j & 8'hE0), c[7:0]};
			tw = $time;
			wr(i[0] ? ADDR_EXT_SEC : ADDR_SEC);
			while ($time < tw + (100 * STEP + 320) * 50) @(posedge clk);
			tr = $time;
			rd(ADDR_HUND, 8);
			h = un(c[31:24]) + 1;
			d = un(c[23:16]);
			m = un(c[15:8]);
			y = un(c[7:0]);
			// Day end: weekday rotates, date, month and year carry
			if (h == 24) begin
				h = 0;
				wd = (wd + 1) % 7;
				d++;
				if (d > mdays(m, y)) begin
					d = 1;
					m++;
				end
				if (m == 13) begin
					m = 1;
					y = (y + 1) % 100;
				end
			end
			eq = {8'h00, 8'h00, bcd(h), 8'h01 << wd, bcd(d), bcd(m), bcd(y)};
			chk_h(rq[0], int'(((tr - tw) / 50 + 24) / STEP) - 100);
			for (int k = 0; k < 7; k++) chk(rq[k + 1], eq[k]);
		end
		// Capture on a rising event edge one second later
		wq = {8'hC0};
		wr(ADDR_EVT);
		while ($time < tw + (200 * STEP + 320) * 50) @(posedge clk);
		ev <= 1'b1;
		te = $time;
		repeat (8) @(posedge clk);
		e = int'(((te - tw) / 50 - 266) / STEP) - 200;
		rd(ADDR_HUND_SNAP, 3);
		chk_h(rq[0], e);
		chk(rq[1], 8'h01);
		chk(rq[2], 8'h00);
		// Snapshots are read-only
		wq = {8'h33};
		wr(ADDR_SEC_SNAP);
		rd(ADDR_HUND_SNAP, 2);
		chk_h(rq[0], e);
		chk(rq[1], 8'h01);
		rd(ADDR_SEC, 1);
		chk(rq[0], 8'h01);
		// Level select low: the falling event edge captures again
		wq = {8'h80};
		wr(ADDR_EVT);
		ev <= 1'b0;
		te = $time;
		repeat (8) @(posedge clk);
		e = int'(((te - tw) / 50 - 266) / STEP) - 200;
		rd(ADDR_HUND_SNAP, 2);
		chk_h(rq[0], e);
		chk(rq[1], 8'h01);
		// General reset bit, then event reset bit, each clear hundredths
		for (int i = 0; i < 2; i++) begin
			wq = {i ? 8'hFF : 8'h01};
			tw = $time;
			wr(i ? ADDR_EVT : ADDR_CTRL);
			tr = $time;
			rd(ADDR_HUND, 1);
			chk_h(rq[0], int'(((tr - tw) / 50 + 24) / STEP));
			rd(i ? ADDR_EVT : ADDR_CTRL, 1);
			chk(rq[0], i ? 8'hF1 : 8'h00);
		end
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
